// >>> src/hvpcs_pkg.sv
package hvpcs_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [7:0] IDX_DATA       = 8'h02;
  localparam logic [7:0] IDX_DIRECTION  = 8'h06;
  localparam logic [7:0] IDX_CONFIG0    = 8'h22;
  localparam logic [7:0] IDX_CONFIG1    = 8'h26;
  localparam logic [7:0] IDX_STATUS     = 8'h27;
  localparam logic [7:0] IDX_INT_STATUS = 8'h29;

  // Port geometry
  localparam int          NUM_PINS   = 7;
  localparam int          NUM_SENSE  = 5;
  localparam int          SYNC_W     = 18;

  // Configuration register 0 fields
  localparam int          CFG0_DIAG_MODE = 7;
  localparam int          CFG0_PIN6_PWM  = 6;
  localparam int          CFG0_PWM_SEL_H = 5;
  localparam int          CFG0_PWM_SEL_L = 4;
  localparam int          CFG0_PIN3_CMP2 = 3;
  localparam int          CFG0_TSEL_H    = 2;

  // Configuration register 1 fields
  localparam int          CFG1_SENSE_IRQ_EN = 7;

  // Status register fields
  localparam int          STAT_SENSE_FLAG = 7;

  // Interrupt status register fields
  localparam int          ISR_CURRENT_LIMIT = 6;

  // Reset values
  localparam logic [6:0]  DIRECTION_RESET = 7'h00;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;
  localparam logic [31:0] RDATA_RESET     = 32'h00000000;

  // PWM pin select encodings
  localparam logic [1:0]  PWM_SEL_PIN0 = 2'h1;
  localparam logic [1:0]  PWM_SEL_PIN4 = 2'h2;
  localparam logic [1:0]  PWM_SEL_PIN5 = 2'h3;

  // AHB transfer type bit that marks an active transfer
  localparam int          HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [1:0] {
    BUS_IDLE    = 2'b00,
    BUS_RD_WAIT = 2'b01
  } hvpcs_bus_type;

endpackage

// >>> src/hvpcs_sense.sv
`timescale 1ns/1ps
`default_nettype none

module hvpcs_sense
  import hvpcs_pkg::*;
(
  // Clock and reset
  input wire logic    hclk,
  input wire logic    hresetn,
  // Sense control and results
  hvpcs_sense_if.unit sif
);

  logic [4:0] sense_result_r;
  logic [4:0] result_prev_r;
  logic       flag_r;
  logic [4:0] result_nxt;
  logic       change;

  always_comb begin
    for (int i = 0; i < NUM_SENSE; i++) begin
      result_nxt[i] = sense_result_r[i];
      if (!sif.sense_enable[i]) begin
        result_nxt[i] = 1'b0;
      end else if (sif.direction[i]) begin
        result_nxt[i] = sif.contact_level[i];
      end else if (sif.below_low[i]) begin
        result_nxt[i] = 1'b1;
      end else if (sif.above_high[i]) begin
        result_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_result_r <= 5'h00;
      result_prev_r  <= 5'h00;
    end else begin
      sense_result_r <= result_nxt;
      result_prev_r  <= sense_result_r;
    end
  end

  // Either edge of an enabled result bit counts
  assign change = |((sense_result_r ^ result_prev_r) & sif.sense_enable);

  // A change in the clearing cycle still sets the flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 1'b0;
    end else if (change) begin
      flag_r <= 1'b1;
    end else if (sif.flag_clear) begin
      flag_r <= 1'b0;
    end
  end

  assign sif.sense_result   = sense_result_r;
  assign sif.sense_irq_flag = flag_r;

endmodule

`default_nettype wire

// >>> src/hvpcs_sense_if.sv
`timescale 1ns/1ps
`default_nettype none

interface hvpcs_sense_if;
  logic [4:0] sense_enable;
  logic [4:0] direction;
  logic [4:0] contact_level;
  logic [4:0] below_low;
  logic [4:0] above_high;
  logic       flag_clear;
  logic [4:0] sense_result;
  logic       sense_irq_flag;

  modport ctrl (
    output sense_enable, direction, contact_level, below_low, above_high, flag_clear,
    input  sense_result, sense_irq_flag
  );

  modport unit (
    input  sense_enable, direction, contact_level, below_low, above_high, flag_clear,
    output sense_result, sense_irq_flag
  );
endinterface

`default_nettype wire

// >>> src/hvpcs_top.sv
// Overview of operation
// - Seven bidirectional high-voltage pins, 0 to 6, each with several functions.
// - Data register at index 0x02, direction register at index 0x06.
// - Reset keeps data, clears direction: pins 0-4 inputs, pins 5-6 off.
// - Direction bit one makes the pin an output, or contact-sense when enabled.
// - Pins 5 and 6 are open-drain only, without pull-up.
// - Pins 0 to 5 share the timer capture and compare channels.
// - Pins 0, 4, 5, 6 can carry the PWM output, chosen by configuration.
// - Sensing needs enable, direction one, data zero (to supply) or one (to ground).
// - Pin 0 senses to supply, pin 4 to ground, pins 1-3 by data bit.
// - Resistance below threshold reads one in status bits 0 to 4.
// - Sensing with direction zero follows the high-voltage input thresholds instead.
// - Any edge of an enabled sense result sets the sense interrupt flag.
// - Sense interrupt request is masked while its enable bit is clear.
// - Diagnostic line: pin 4 output plus line-mode bit; driver limits overcurrent.
// - Pin-4 current-limit state shows at interrupt status bit 6.
// - Current-limit polarity depends on device variant.
// - Capture channel 1 routed to pin 4 takes the pin level, readable elsewhere.
// - Pins 5 and 6 driven from data bits or from the PWM output; pin 5 also from compare 1.
// - Writing one clears the sense interrupt flag; zero leaves it.
// - Line-mode one: pin 4 low-side only; zero: push-pull.
// - Sense interrupt enable gates contact-sense interrupts of pins 0 to 4.
`timescale 1ns/1ps
`default_nettype none

module hvpcs_top
  import hvpcs_pkg::*;
#(
  parameter bit LIMIT_INVERTED = 1'b0
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Port pins
  input  wire logic [6:0]  pin_in,
  output logic [6:0]       pin_out,
  output logic [6:0]       pin_oe,
  // Analog sense front end
  input  wire logic [4:0]  contact_level,
  input  wire logic [4:0]  hv_input_low_threshold,
  input  wire logic [4:0]  hv_input_high_threshold,
  input  wire logic        pin4_overcurrent,
  output logic [4:0]       sense_bias,
  output logic [4:0]       sense_to_ground,
  output logic             diag_bias_enable,
  // Timer and PWM
  input  wire logic        timer_compare1,
  input  wire logic        timer_compare2,
  input  wire logic        pwm_in,
  output logic             timer_capture1,
  output logic             timer_capture2,
  // Interrupt request
  output logic             sense_irq
);

  hvpcs_sense_if sif ();

  hvpcs_bus_type bus_state_r;
  logic          hreadyout_r;
  logic          hresp_r;
  logic [31:0]   hrdata_r;
  logic [7:0]    addr_idx_r;
  logic          wr_pend_r;
  logic          take;
  logic          wr_commit;

  logic [6:0]    port_data_r;
  logic [6:0]    direction_r;
  logic [7:0]    config0_r;
  logic [7:0]    config1_r;

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [6:0]        pin_s;
  logic [4:0]        contact_s;
  logic [4:0]        low_s;
  logic [4:0]        high_s;
  logic              overcurrent_s;

  logic [6:0]    pin_out_r;
  logic [6:0]    pin_oe_r;
  logic [4:0]    sense_bias_r;
  logic [4:0]    sense_to_ground_r;
  logic          diag_bias_r;
  logic          capture1_r;
  logic          capture2_r;
  logic          sense_irq_r;

  logic [6:0]    pin_value;
  logic [6:0]    pin_out_nxt;
  logic [6:0]    pin_oe_nxt;
  logic [6:0]    cmp1_route;
  logic [6:0]    pwm_route;
  logic [4:0]    sense_en;
  logic          current_limit;

  // Word index of a byte address
  function automatic logic [7:0] word_index(input logic [31:0] addr);
    return addr[9:2];
  endfunction

  // Byte into the low lane of a data word
  function automatic logic [31:0] low_byte(input logic [7:0] value);
    return {24'h000000, value};
  endfunction

  // Analog inputs and pins are asynchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {1'b0, pin4_overcurrent, hv_input_high_threshold, hv_input_low_threshold,
                  contact_level, pin_in[0]};
      sync2_r <= sync1_r;
    end
  end

  // The pin vector is synchronised alongside the front-end signals
  logic [5:0] pin_hi_s1_r;
  logic [5:0] pin_hi_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_hi_s1_r <= 6'h00;
      pin_hi_s2_r <= 6'h00;
    end else begin
      pin_hi_s1_r <= pin_in[6:1];
      pin_hi_s2_r <= pin_hi_s1_r;
    end
  end

  assign pin_s         = {pin_hi_s2_r, sync2_r[0]};
  assign contact_s     = sync2_r[5:1];
  assign low_s         = sync2_r[10:6];
  assign high_s        = sync2_r[15:11];
  assign overcurrent_s = sync2_r[16];

  // Bit 17 of the sync chain is spare
  logic unused_sync;
  assign unused_sync = sync2_r[17];

  // AHB-Lite slave: writes take no wait state, reads one
  assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_r <= BUS_IDLE;
      hreadyout_r <= 1'b1;
      addr_idx_r  <= 8'h00;
      wr_pend_r   <= 1'b0;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          wr_pend_r <= take && hwrite;
          if (take) begin
            addr_idx_r <= word_index(haddr);
          end
          // Read waits so a write just ahead of it has landed
          if (take && !hwrite) begin
            bus_state_r <= BUS_RD_WAIT;
            hreadyout_r <= 1'b0;
          end
        end
        BUS_RD_WAIT: begin
          wr_pend_r   <= 1'b0;
          bus_state_r <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
        default: begin
          bus_state_r <= BUS_IDLE;
          hreadyout_r <= 1'b1;
          wr_pend_r   <= 1'b0;
        end
      endcase
    end
  end

  assign wr_commit = wr_pend_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= RDATA_RESET;
    end else if (bus_state_r == BUS_RD_WAIT) begin
      case (addr_idx_r)
        IDX_DATA:       hrdata_r <= low_byte({1'b0,
                                   (direction_r & port_data_r) | (~direction_r & pin_s)});
        IDX_DIRECTION:  hrdata_r <= low_byte({1'b0, direction_r});
        IDX_CONFIG0:    hrdata_r <= low_byte(config0_r);
        IDX_CONFIG1:    hrdata_r <= low_byte(config1_r);
        IDX_STATUS:     hrdata_r <= low_byte({sif.sense_irq_flag, 2'b00,
                                              sif.sense_result});
        IDX_INT_STATUS: hrdata_r <= low_byte({1'b0, current_limit, 6'h00});
        default:        hrdata_r <= RDATA_RESET;
      endcase
    end
  end

  // Data register is deliberately left alone by reset
  always_ff @(posedge hclk) begin
    if (wr_commit && addr_idx_r == IDX_DATA) begin
      port_data_r <= hwdata[6:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      direction_r <= DIRECTION_RESET;
    end else if (wr_commit && addr_idx_r == IDX_DIRECTION) begin
      direction_r <= hwdata[6:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config0_r <= CONFIG_RESET;
    end else if (wr_commit && addr_idx_r == IDX_CONFIG0) begin
      config0_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config1_r <= CONFIG_RESET;
    end else if (wr_commit && addr_idx_r == IDX_CONFIG1) begin
      config1_r <= hwdata[7:0];
    end
  end

  // Contact sensing
  assign sense_en = config1_r[NUM_SENSE-1:0];

  assign sif.sense_enable  = sense_en;
  assign sif.direction     = direction_r[4:0];
  assign sif.contact_level = contact_s;
  assign sif.below_low     = low_s;
  assign sif.above_high    = high_s;
  assign sif.flag_clear    = wr_commit && addr_idx_r == IDX_STATUS &&
                             hwdata[STAT_SENSE_FLAG];

  hvpcs_sense u_sense (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sif     (sif)
  );

  // Current limit with variant polarity
  assign current_limit = LIMIT_INVERTED ? !overcurrent_s : overcurrent_s;

  // Special signal routing
  always_comb begin
    cmp1_route = 7'h00;
    case (config0_r[CFG0_TSEL_H:0])
      3'b010, 3'b011: cmp1_route[0] = 1'b1;
      3'b100, 3'b101: cmp1_route[1] = 1'b1;
      3'b110:         cmp1_route[4] = 1'b1;
      3'b111:         cmp1_route[5] = 1'b1;
      default:        cmp1_route = 7'h00;
    endcase
    pwm_route = 7'h00;
    case (config0_r[CFG0_PWM_SEL_H:CFG0_PWM_SEL_L])
      PWM_SEL_PIN0: pwm_route[0] = 1'b1;
      PWM_SEL_PIN4: pwm_route[4] = 1'b1;
      PWM_SEL_PIN5: pwm_route[5] = 1'b1;
      default:      pwm_route = 7'h00;
    endcase
    pwm_route[6] = config0_r[CFG0_PIN6_PWM];
  end

  // Compare wins on pins 0 and 4, PWM wins on pin 5
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_value[i] = port_data_r[i];
      if (i == 5 && pwm_route[i]) begin
        pin_value[i] = pwm_in;
      end else if (cmp1_route[i]) begin
        pin_value[i] = timer_compare1;
      end else if (i == 3 && config0_r[CFG0_PIN3_CMP2]) begin
        pin_value[i] = timer_compare2;
      end else if (pwm_route[i]) begin
        pin_value[i] = pwm_in;
      end
    end
  end

  // Pin drivers
  always_comb begin
    pin_out_nxt = 7'h00;
    pin_oe_nxt  = 7'h00;
    for (int i = 0; i < NUM_SENSE; i++) begin
      // Sensing pins are biased by the analog block, not driven
      if (direction_r[i] && !sense_en[i]) begin
        pin_out_nxt[i] = pin_value[i];
        pin_oe_nxt[i]  = 1'b1;
      end
    end
    if (direction_r[4] && !sense_en[4] && config0_r[CFG0_DIAG_MODE]) begin
      pin_out_nxt[4] = 1'b0;
      pin_oe_nxt[4]  = !pin_value[4];
    end
    for (int i = NUM_SENSE; i < NUM_PINS; i++) begin
      pin_out_nxt[i] = 1'b0;
      pin_oe_nxt[i]  = direction_r[i] && pin_value[i];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_r <= 7'h00;
      pin_oe_r  <= 7'h00;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r  <= pin_oe_nxt;
    end
  end

  // Sense bias and direction toward supply or ground
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_bias_r      <= 5'h00;
      sense_to_ground_r <= 5'h00;
      diag_bias_r       <= 1'b0;
    end else begin
      sense_bias_r      <= sense_en & direction_r[4:0];
      sense_to_ground_r <= {1'b1, port_data_r[3:1] & sense_en[3:1] & direction_r[3:1],
                            1'b0};
      diag_bias_r       <= direction_r[4] && config0_r[CFG0_DIAG_MODE];
    end
  end

  // Capture inputs and interrupt request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture1_r  <= 1'b0;
      capture2_r  <= 1'b0;
      sense_irq_r <= 1'b0;
    end else begin
      capture1_r  <= config0_r[0] ? pin_s[4] : pin_s[0];
      capture2_r  <= pin_s[2];
      sense_irq_r <= sif.sense_irq_flag && config1_r[CFG1_SENSE_IRQ_EN];
    end
  end

  assign hreadyout        = hreadyout_r;
  assign hresp            = hresp_r;
  assign hrdata           = hrdata_r;
  assign pin_out          = pin_out_r;
  assign pin_oe           = pin_oe_r;
  assign sense_bias       = sense_bias_r;
  assign sense_to_ground  = sense_to_ground_r;
  assign diag_bias_enable = diag_bias_r;
  assign timer_capture1   = capture1_r;
  assign timer_capture2   = capture2_r;
  assign sense_irq        = sense_irq_r;

endmodule

`default_nettype wire

// >>> test/hvpcs_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module hvpcs_load_model (
  // Clock
  input wire logic       hclk,
  // Design side
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [4:0] sense_bias,
  // Bench controls
  input wire logic [4:0] ext_level,
  input wire logic [4:0] sw_closed,
  input wire logic       short4,
  // Toward design
  output logic [6:0]     pin_in,
  output logic [4:0]     contact_level,
  output logic [4:0]     hv_low,
  output logic [4:0]     hv_high,
  output logic           pin4_overcurrent
);
  logic [1:0] float_r = 2'h1;

  // No pull-up on the sink pins, so a released pin wanders every cycle
  always_ff @(posedge hclk) float_r <= ~float_r;
  assign pin_in[6:5] = ~pin_oe[6:5] & float_r;
  assign pin_in[4:0] = (pin_oe[4:0] & pin_out[4:0]) | (~pin_oe[4:0] & ext_level);
  // A closed switch only reads as low resistance while the pin is biased
  assign contact_level = sense_bias & sw_closed;
  assign hv_low = ~ext_level;
  assign hv_high = ext_level;
  assign pin4_overcurrent = short4 & pin_oe[4] & ~pin_out[4];
endmodule

`default_nettype wire

// >>> test/hvpcs_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module hvpcs_monitor (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Bus
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  // Pins and sense
  input wire logic [6:0] pin_in,
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [4:0] sense_bias,
  input wire logic [4:0] sense_to_ground,
  input wire logic       diag_bias_enable,
  input wire logic       timer_capture2
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_read_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read without exactly one wait state");

  property p_write_nowait;
    hsel && htrans[1] && hready && hwrite |=> hreadyout;
  endproperty
  a_write_nowait: assert property (p_write_nowait)
    else $error("write data phase stalled");

  property p_okay;
    hresp == 1'h0;
  endproperty
  a_okay: assert property (p_okay)
    else $error("error response seen");

  property p_open_drain;
    (pin_oe[6:5] & pin_out[6:5]) == 2'h0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("low-side pin driven high");

  property p_line_low;
    diag_bias_enable && pin_oe[4] |-> !pin_out[4];
  endproperty
  a_line_low: assert property (p_line_low)
    else $error("line mode pin driven high");

  property p_sense_no_drive;
    (sense_bias & pin_oe[4:0]) == 5'h00;
  endproperty
  a_sense_no_drive: assert property (p_sense_no_drive)
    else $error("sensing pin also driven");

  property p_sense_ground;
    $past(hresetn) |-> sense_to_ground[4] && !sense_to_ground[0]
      && (sense_to_ground[3:1] & ~sense_bias[3:1]) == 3'h0;
  endproperty
  a_sense_ground: assert property (p_sense_ground)
    else $error("sense direction wrong");

  property p_capture2;
    $past(hresetn, 1) && $past(hresetn, 2) && $past(hresetn, 3)
      |-> timer_capture2 == $past(pin_in[2], 3);
  endproperty
  a_capture2: assert property (p_capture2)
    else $error("capture 2 does not follow pin 2");

  property p_reset_off;
    $rose(hresetn) |-> pin_oe == 7'h00 && sense_bias == 5'h00 && !diag_bias_enable;
  endproperty
  a_reset_off: assert property (p_reset_off)
    else $error("pins not released after reset");
endmodule

`default_nettype wire

// >>> test/test_hv_port_contact_sense.sv
`timescale 1ns/1ps
`default_nettype none

module test_hv_port_contact_sense;
  import hvpcs_pkg::*;

  localparam bit INV = 1'h0;
  logic        hclk, hresetn, hwrite, pwm_in, tcmp2, short4, hvo;
  logic        hreadyout, hresp, timer_capture1, timer_capture2, sense_irq, diag_bias_enable;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [6:0]  pin_in, pin_out, pin_oe;
  logic [4:0]  contact_level, hv_low, hv_high, sense_bias, sense_to_ground, ext_level, sw_closed;
  logic [7:0]  rnd, d;
  int          mismatches, compares;

  hvpcs_top #(.LIMIT_INVERTED(INV)) uut (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .pin_in, .pin_out, .pin_oe, .contact_level, .hv_input_low_threshold(hv_low),
    .hv_input_high_threshold(hv_high), .pin4_overcurrent(hvo), .sense_bias,
    .sense_to_ground, .diag_bias_enable, .timer_compare1(tcmp2), .timer_compare2(tcmp2),
    .pwm_in, .timer_capture1, .timer_capture2, .sense_irq);

  hvpcs_load_model load (.hclk, .pin_out, .pin_oe, .sense_bias, .ext_level, .sw_closed,
    .short4, .pin_in, .contact_level, .hv_low, .hv_high, .pin4_overcurrent(hvo));

  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Sink pins only switch on when their bit is set
  function automatic logic [6:0] exp_oe(input logic [7:0] v);
    return {v[6:5], 5'h1F};
  endfunction
  function automatic logic [7:0] exp_limit(input logic over);
    return {1'h0, over ^ INV, 6'h00};
  endfunction

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] rd;
    bus(1'h1, idx, {24'h0, v}, rd);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    bus(1'h0, idx, 32'h0, rd);
    compares++;
    if (rd !== {24'h0, exp}) begin
      mismatches++;
      $display("unexpected at %0t: reg %h read %h want %h", $time, idx, rd, exp);
    end
  endtask
  task automatic pin_chk(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: pins %b want %b", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    end_sim;
  end

  initial begin
    {hresetn, hwrite, pwm_in, tcmp2, short4, htrans} = '0;
    {haddr, hwdata, sw_closed} = '0;
    ext_level = 5'h1F;
    rnd = 8'h2F;
    mismatches = 0;
    compares = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    rd_chk(IDX_DIRECTION, 8'h00);
    pin_chk(pin_oe, 7'h00);
    rd_chk(8'h10, 8'h00);
    wr(IDX_DIRECTION, 8'h7F);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      d = (i == 0) ? 8'h7F : (i == 1) ? 8'h00 : rnd & 8'h7F;
      wr(IDX_DATA, d);
      rd_chk(IDX_DATA, d);
      pin_chk(pin_oe, exp_oe(d));
      pin_chk(pin_out, {2'h0, d[4:0]});
    end
    // Line driver on pin 4, then a short while it sinks
    wr(IDX_CONFIG0, 8'h80);
    wr(IDX_DIRECTION, 8'h10);
    wr(IDX_DATA, 8'h10);
    repeat (3) @(posedge hclk);
    pin_chk({6'h0, diag_bias_enable}, 7'h01);
    pin_chk({6'h0, pin_oe[4]}, 7'h00);
    wr(IDX_DATA, 8'h00);
    short4 <= 1'h1;
    repeat (6) @(posedge hclk);
    rd_chk(IDX_INT_STATUS, exp_limit(1'h1));
    short4 <= 1'h0;
    repeat (6) @(posedge hclk);
    rd_chk(IDX_INT_STATUS, exp_limit(1'h0));
    // Modulated output on both sink pins
    wr(IDX_CONFIG0, 8'h70);
    wr(IDX_DIRECTION, 8'h60);
    for (int v = 1; v >= 0; v--) begin
      pwm_in <= v[0];
      repeat (3) @(posedge hclk);
      pin_chk({5'h0, pin_oe[6:5]}, {5'h0, v[0], v[0]});
    end
    // Compare 1 out on pin 1, compare 2 on pin 3, capture 1 taken from pin 4
    wr(IDX_CONFIG0, 8'h0D);
    wr(IDX_DIRECTION, 8'h0A);
    for (int v = 1; v >= 0; v--) begin
      tcmp2 <= v[0];
      ext_level <= v[0] ? 5'h1F : 5'h00;
      repeat (6) @(posedge hclk);
      pin_chk({4'h0, timer_capture1, pin_out[3], pin_out[1]}, {4'h0, v[0], v[0], v[0]});
    end
    // Contact sense on pins 0 and 1
    wr(IDX_CONFIG0, 8'h00);
    ext_level <= 5'h1F;
    wr(IDX_DATA, 8'h02);
    wr(IDX_DIRECTION, 8'h03);
    wr(IDX_CONFIG1, 8'h83);
    wr(IDX_STATUS, 8'h80);
    pin_chk({2'h0, sense_to_ground}, 7'h12);
    pin_chk({2'h0, sense_bias}, 7'h03);
    sw_closed <= 5'h01;
    repeat (10) @(posedge hclk);
    rd_chk(IDX_STATUS, 8'h81);
    pin_chk({6'h0, sense_irq}, 7'h01);
    wr(IDX_STATUS, 8'h7F);
    rd_chk(IDX_STATUS, 8'h81);
    wr(IDX_STATUS, 8'h80);
    rd_chk(IDX_STATUS, 8'h01);
    wr(IDX_CONFIG1, 8'h03);
    sw_closed <= 5'h00;
    repeat (10) @(posedge hclk);
    rd_chk(IDX_STATUS, 8'h80);
    pin_chk({6'h0, sense_irq}, 7'h00);
    wr(IDX_DIRECTION, 8'h01);
    ext_level <= 5'h1D;
    repeat (8) @(posedge hclk);
    rd_chk(IDX_STATUS, 8'h82);
    end_sim;
  end
endmodule

bind hvpcs_top hvpcs_monitor mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .sense_bias, .sense_to_ground,
  .diag_bias_enable, .timer_capture2);

`default_nettype wire
